// *** hw/ccm_consts.svh ***
// Offsets, field positions, reset values and masks of the config mirror block
`ifndef CCM_CONSTS_SVH
`define CCM_CONSTS_SVH

`define CCM_OFS_COMMAND 12'h000
`define CCM_OFS_DEVCTL2 12'h004
`define CCM_OFS_STATUS 12'h008

`define CCM_CMD_MEM_BIT 1
`define CCM_CMD_SERR_BIT 8

`define CCM_DC2_TO_VAL_LSB 0
`define CCM_DC2_TO_DIS_BIT 4
`define CCM_DC2_ARI_BIT 5
`define CCM_DC2_ATOM_REQ_BIT 6
`define CCM_DC2_ATOM_BLK_BIT 7
`define CCM_DC2_IDO_REQ_BIT 8
`define CCM_DC2_IDO_CPL_BIT 9
`define CCM_DC2_LTR_BIT 10
`define CCM_DC2_PFX_BLK_BIT 15
`define CCM_DC2_WMASK 16'h87FF

`define CCM_STS_PFX_BIT 0
`define CCM_STS_UR_BIT 1
`define CCM_STS_ATOM_BIT 2

`define CCM_RST_CMD 1'b0
`define CCM_RST_DC2 16'h0000
`define CCM_RST_STS 3'h0

`endif

// *** hw/ccm_pkg.sv ***
// Types shared by the config mirror block
`default_nettype none
package ccm_pkg;
    typedef enum logic [1:0] {
        CCM_PKT_PLAIN = 2'b00,
        CCM_PKT_ATOMIC = 2'b01,
        CCM_PKT_ERR_FWD = 2'b10,
        CCM_PKT_CFG_T1 = 2'b11
    } ccm_pkt_kind_t;

    typedef struct packed {
        logic valid;
        logic is_mem;
        logic non_posted;
        logic [7:0] tag;
    } ccm_in_req_t;

    typedef struct packed {
        logic valid;
        ccm_pkt_kind_t kind;
        logic has_prefix;
        logic [4:0] dev_num;
    } ccm_eg_pkt_t;

    typedef struct packed {
        logic valid;
        ccm_pkt_kind_t kind;
        logic has_prefix;
        logic to_type0;
        logic [4:0] dev_num;
    } ccm_eg_out_t;
endpackage
`default_nettype wire

// *** hw/ccm_ingress_filter.sv ***
// Inbound memory request filter driven by memory space enable
`default_nettype none
module ccm_ingress_filter #(
    parameter bit ROOT_PORT = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic mem_enable,
    input wire ccm_pkg::ccm_in_req_t in_req,
    output ccm_pkg::ccm_in_req_t fwd_out,
    output ccm_pkg::ccm_in_req_t ur_out
);
    ccm_pkg::ccm_in_req_t fwd_ff, nxt_fwd, ur_ff, nxt_ur;

    always_comb begin
        nxt_fwd = '0;
        nxt_ur = '0;
        if (in_req.valid) begin
            if (!ROOT_PORT && in_req.is_mem && !mem_enable) begin
                if (in_req.non_posted) begin
                    nxt_ur = in_req;
                end
            end else begin
                nxt_fwd = in_req;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fwd_ff <= '0;
            ur_ff <= '0;
        end else begin
            fwd_ff <= nxt_fwd;
            ur_ff <= nxt_ur;
        end
    end

    assign fwd_out = fwd_ff;
    assign ur_out = ur_ff;

    ////////////////////////////////////////////////////////////////////////
    a_mem_ur_answer: assert property (@(posedge clk) disable iff (rst)
        (!ROOT_PORT && in_req.valid && in_req.is_mem && !mem_enable)
        |=> !fwd_out.valid && (ur_out.valid == $past(in_req.non_posted)))
        else $error("Disabled memory request not filtered");
    a_mem_pass_on: assert property (@(posedge clk) disable iff (rst)
        (in_req.valid && in_req.is_mem && mem_enable)
        |=> fwd_out.valid && fwd_out.tag == $past(in_req.tag) && !ur_out.valid)
        else $error("Enabled memory request not passed");
    a_root_no_filter: assert property (@(posedge clk) disable iff (rst)
        (ROOT_PORT && in_req.valid) |=> fwd_out.valid && !ur_out.valid)
        else $error("Root port filtered a request");
endmodule
`default_nettype wire

// *** hw/ccm_egress_filter.sv ***
// Outbound packet gate for atomics, prefixes, error forwarding and ARI
`default_nettype none
module ccm_egress_filter #(
    parameter bit ROOT_PORT = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic serr_enable,
    input wire logic ari_forward,
    input wire logic atomic_block,
    input wire logic prefix_block,
    input wire ccm_pkg::ccm_eg_pkt_t in_pkt,
    output ccm_pkg::ccm_eg_out_t out_pkt,
    output logic prefix_err,
    output logic atomic_err
);
    ccm_pkg::ccm_eg_out_t out_ff, nxt_out;
    logic pfx_ff, nxt_pfx, atom_ff, nxt_atom;
    logic blk_pfx, blk_atom, blk_err;

    always_comb begin
        blk_pfx = in_pkt.has_prefix && prefix_block;
        blk_atom = (in_pkt.kind == ccm_pkg::CCM_PKT_ATOMIC) && atomic_block;
        blk_err = ROOT_PORT && (in_pkt.kind == ccm_pkg::CCM_PKT_ERR_FWD) && !serr_enable;
        nxt_out = '0;
        nxt_pfx = in_pkt.valid && blk_pfx;
        nxt_atom = in_pkt.valid && blk_atom;
        if (in_pkt.valid && !blk_pfx && !blk_atom && !blk_err) begin
            nxt_out.valid = 1'b1;
            nxt_out.kind = in_pkt.kind;
            nxt_out.has_prefix = in_pkt.has_prefix;
            nxt_out.dev_num = in_pkt.dev_num;
            if (in_pkt.kind == ccm_pkg::CCM_PKT_CFG_T1) begin
                nxt_out.to_type0 = 1'b1;
                if (!ari_forward) begin
                    nxt_out.dev_num = 5'h00;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_ff <= '0;
            pfx_ff <= 1'b0;
            atom_ff <= 1'b0;
        end else begin
            out_ff <= nxt_out;
            pfx_ff <= nxt_pfx;
            atom_ff <= nxt_atom;
        end
    end

    assign out_pkt = out_ff;
    assign prefix_err = pfx_ff;
    assign atomic_err = atom_ff;

    ////////////////////////////////////////////////////////////////////////
    a_atomic_blocked: assert property (@(posedge clk) disable iff (rst)
        (in_pkt.valid && in_pkt.kind == ccm_pkg::CCM_PKT_ATOMIC && atomic_block)
        |=> !out_pkt.valid && atomic_err)
        else $error("Atomic request left while blocked");
    a_prefix_blocked: assert property (@(posedge clk) disable iff (rst)
        (in_pkt.valid && in_pkt.has_prefix && prefix_block) |=> !out_pkt.valid && prefix_err)
        else $error("Prefixed packet left while blocked");
    a_prefix_allowed: assert property (@(posedge clk) disable iff (rst)
        (in_pkt.valid && in_pkt.kind == ccm_pkg::CCM_PKT_PLAIN && !prefix_block)
        |=> out_pkt.valid && !prefix_err)
        else $error("Plain packet dropped while unblocked");
    a_err_fwd_gate: assert property (@(posedge clk) disable iff (rst)
        (ROOT_PORT && in_pkt.valid && in_pkt.kind == ccm_pkg::CCM_PKT_ERR_FWD
         && !in_pkt.has_prefix) |=> (out_pkt.valid == $past(serr_enable)))
        else $error("Error forwarding not gated by system error enable");
    a_ari_dev_num: assert property (@(posedge clk) disable iff (rst)
        (in_pkt.valid && in_pkt.kind == ccm_pkg::CCM_PKT_CFG_T1 && !in_pkt.has_prefix)
        |=> out_pkt.to_type0
            && out_pkt.dev_num == ($past(ari_forward) ? $past(in_pkt.dev_num) : 5'h00))
        else $error("Device number handling wrong on conversion");
endmodule
`default_nettype wire

// *** hw/ccm_top.sv ***
// Config control mirror: APB register bank, mirrored outputs, packet gates
//
// Chosen here: the APB register port and the placing of the registers.
`default_nettype none
`include "ccm_consts.svh"
module ccm_top #(
    parameter bit ROOT_PORT = 1'b0,
    parameter bit ARI_FWD_SUPPORTED = 1'b1,
    parameter bit IDO_REQ_FIXED_ZERO = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ccm_pkg::ccm_in_req_t in_req,
    output ccm_pkg::ccm_in_req_t in_fwd,
    output ccm_pkg::ccm_in_req_t in_ur,
    input wire ccm_pkg::ccm_eg_pkt_t eg_pkt,
    output ccm_pkg::ccm_eg_out_t eg_out,
    output logic memory_space_enable_out,
    output logic system_error_enable_out,
    output logic alt_routing_forward_enable_out,
    output logic atomic_egress_block_out,
    output logic atomic_requester_enable_out,
    output logic completion_timeout_disable_out,
    output logic [3:0] completion_timeout_range_out,
    output logic id_order_completion_enable_out,
    output logic id_order_request_enable_out,
    output logic latency_report_enable_out,
    output logic prefix_block_out,
    output logic aux_power_enable_out
);
    ////////////////////////////////////////////////////////////////////////
    // Address decode
    function automatic logic [2:0] ccm_decode(input logic [11:0] a);
        logic [2:0] r;
        r = 3'h0;
        if (a == `CCM_OFS_COMMAND) begin
            r = 3'h4;
        end else if (a == `CCM_OFS_DEVCTL2) begin
            r = 3'h5;
        end else if (a == `CCM_OFS_STATUS) begin
            r = 3'h6;
        end
        return r;
    endfunction

    logic [2:0] dec;
    logic wr_commit, access_first;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    assign dec = ccm_decode(paddr);
    assign access_first = psel && penable && !pready_ff;
    assign wr_commit = psel && penable && pready_ff && pwrite;

    ////////////////////////////////////////////////////////////////////////
    // Bus answer
    logic [31:0] prdata_ff, nxt_prdata;
    logic mem_en_ff, nxt_mem_en, serr_ff, nxt_serr;
    logic [15:0] dc2_ff, nxt_dc2;
    logic [2:0] sts_ff, nxt_sts;

    always_comb begin
        nxt_pready = access_first;
        nxt_pslverr = access_first && !dec[2];
        nxt_prdata = 32'h0000_0000;
        if (access_first && !pwrite) begin
            case (dec)
                3'h4: begin
                    nxt_prdata[`CCM_CMD_MEM_BIT] = mem_en_ff;
                    nxt_prdata[`CCM_CMD_SERR_BIT] = serr_ff;
                end
                3'h5: begin
                    nxt_prdata[15:0] = dc2_ff;
                end
                3'h6: begin
                    nxt_prdata[2:0] = sts_ff;
                end
                default: begin
                    nxt_prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata = prdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // Command and device control 2 registers
    always_comb begin
        nxt_mem_en = mem_en_ff;
        nxt_serr = serr_ff;
        nxt_dc2 = dc2_ff;
        if (wr_commit && dec == 3'h4) begin
            nxt_mem_en = pwdata[`CCM_CMD_MEM_BIT];
            nxt_serr = pwdata[`CCM_CMD_SERR_BIT];
        end
        if (wr_commit && dec == 3'h5) begin
            nxt_dc2 = pwdata[15:0] & `CCM_DC2_WMASK;
            if (!ARI_FWD_SUPPORTED) begin
                nxt_dc2[`CCM_DC2_ARI_BIT] = 1'b0;
            end
            if (IDO_REQ_FIXED_ZERO) begin
                nxt_dc2[`CCM_DC2_IDO_REQ_BIT] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_en_ff <= `CCM_RST_CMD;
            serr_ff <= `CCM_RST_CMD;
            dc2_ff <= `CCM_RST_DC2;
        end else begin
            mem_en_ff <= nxt_mem_en;
            serr_ff <= nxt_serr;
            dc2_ff <= nxt_dc2;
        end
    end

    // Mirrors straight from the stored bits
    assign memory_space_enable_out = mem_en_ff;
    assign system_error_enable_out = serr_ff;
    assign completion_timeout_range_out = dc2_ff[`CCM_DC2_TO_VAL_LSB +: 4];
    assign completion_timeout_disable_out = dc2_ff[`CCM_DC2_TO_DIS_BIT];
    assign alt_routing_forward_enable_out = dc2_ff[`CCM_DC2_ARI_BIT];
    assign atomic_requester_enable_out = dc2_ff[`CCM_DC2_ATOM_REQ_BIT];
    assign atomic_egress_block_out = dc2_ff[`CCM_DC2_ATOM_BLK_BIT];
    assign id_order_request_enable_out = dc2_ff[`CCM_DC2_IDO_REQ_BIT];
    assign id_order_completion_enable_out = dc2_ff[`CCM_DC2_IDO_CPL_BIT];
    assign latency_report_enable_out = dc2_ff[`CCM_DC2_LTR_BIT];
    assign prefix_block_out = dc2_ff[`CCM_DC2_PFX_BLK_BIT];

    // Unused mirror, held low
    logic aux_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aux_ff <= 1'b0;
        end else begin
            aux_ff <= 1'b0;
        end
    end
    assign aux_power_enable_out = aux_ff;

    ////////////////////////////////////////////////////////////////////////
    // Packet gates
    logic pfx_err, atom_err;

    ccm_ingress_filter #(
        .ROOT_PORT(ROOT_PORT)
    ) u_ingress (
        .clk(clk),
        .rst(rst),
        .mem_enable(mem_en_ff),
        .in_req(in_req),
        .fwd_out(in_fwd),
        .ur_out(in_ur)
    );

    ccm_egress_filter #(
        .ROOT_PORT(ROOT_PORT)
    ) u_egress (
        .clk(clk),
        .rst(rst),
        .serr_enable(serr_ff),
        .ari_forward(dc2_ff[`CCM_DC2_ARI_BIT]),
        .atomic_block(dc2_ff[`CCM_DC2_ATOM_BLK_BIT]),
        .prefix_block(dc2_ff[`CCM_DC2_PFX_BLK_BIT]),
        .in_pkt(eg_pkt),
        .out_pkt(eg_out),
        .prefix_err(pfx_err),
        .atomic_err(atom_err)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sticky event status, write one to clear, set wins
    logic [2:0] sts_set, sts_clr;
    always_comb begin
        sts_set = 3'h0;
        sts_set[`CCM_STS_PFX_BIT] = pfx_err;
        sts_set[`CCM_STS_UR_BIT] = in_ur.valid;
        sts_set[`CCM_STS_ATOM_BIT] = atom_err;
        sts_clr = (wr_commit && dec == 3'h6) ? pwdata[2:0] : 3'h0;
        nxt_sts = (sts_ff & ~sts_clr) | sts_set;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sts_ff <= `CCM_RST_STS;
        end else begin
            sts_ff <= nxt_sts;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_mem_en_follow: assert property (@(posedge clk) disable iff (rst)
        (wr_commit && dec == 3'h4)
        |=> memory_space_enable_out == $past(pwdata[`CCM_CMD_MEM_BIT]))
        else $error("Memory space enable did not follow write");
    a_serr_follow: assert property (@(posedge clk) disable iff (rst)
        (wr_commit && dec == 3'h4)
        |=> system_error_enable_out == $past(pwdata[`CCM_CMD_SERR_BIT]))
        else $error("System error enable did not follow write");
    a_dc2_follow: assert property (@(posedge clk) disable iff (rst)
        (wr_commit && dec == 3'h5)
        |=> completion_timeout_range_out == $past(pwdata[3:0])
            && prefix_block_out == $past(pwdata[`CCM_DC2_PFX_BLK_BIT]))
        else $error("Device control 2 mirror did not follow write");
    a_mirror_hold: assert property (@(posedge clk) disable iff (rst)
        !(wr_commit && dec[2:1] == 2'b10) |=> $stable(dc2_ff) && $stable(mem_en_ff))
        else $error("Mirror changed without a write");
    a_ari_fixed_zero: assert property (@(posedge clk) disable iff (rst)
        !ARI_FWD_SUPPORTED |-> !alt_routing_forward_enable_out)
        else $error("ARI forwarding set while unsupported");
    a_dc2_reset_val: assert property (@(posedge clk) disable iff (rst)
        $past(rst) |-> !atomic_egress_block_out && !alt_routing_forward_enable_out
            && !prefix_block_out && !id_order_request_enable_out)
        else $error("Device control 2 not zero after reset");
    a_pfx_sticky: assert property (@(posedge clk) disable iff (rst)
        pfx_err |=> sts_ff[`CCM_STS_PFX_BIT])
        else $error("Prefix blocked error not recorded");
    a_bus_answer: assert property (@(posedge clk) disable iff (rst)
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("Bus answer not one wait state");
    a_serr_hold: assert property (@(posedge clk) disable iff (rst)
        !(wr_commit && dec == 3'h4) |=> $stable(serr_ff))
        else $error("System error enable changed without a write");
    a_dc2_bits_follow: assert property (@(posedge clk) disable iff (rst)
        (wr_commit && dec == 3'h5)
        |=> completion_timeout_disable_out == $past(pwdata[`CCM_DC2_TO_DIS_BIT])
            && atomic_requester_enable_out == $past(pwdata[`CCM_DC2_ATOM_REQ_BIT]))
        else $error("Device control 2 bits did not follow write");
    a_dc2_mask: assert property (@(posedge clk) disable iff (rst)
        (dc2_ff & ~`CCM_DC2_WMASK) == 16'h0000)
        else $error("Reserved device control 2 bit set");
    a_ido_req_fixed: assert property (@(posedge clk) disable iff (rst)
        IDO_REQ_FIXED_ZERO |-> !id_order_request_enable_out)
        else $error("IDO request enable set while fixed at zero");
    a_cmd_read_data: assert property (@(posedge clk) disable iff (rst)
        (psel && penable && !pready && !pwrite && dec == 3'h4)
        |=> prdata[`CCM_CMD_SERR_BIT] == $past(serr_ff)
            && prdata[`CCM_CMD_MEM_BIT] == $past(mem_en_ff))
        else $error("Command read data wrong");
    a_dc2_read_data: assert property (@(posedge clk) disable iff (rst)
        (psel && penable && !pready && !pwrite && dec == 3'h5)
        |=> prdata == {16'h0000, $past(dc2_ff)})
        else $error("Device control 2 read data wrong");
    a_unmapped_refused: assert property (@(posedge clk) disable iff (rst)
        (psel && penable && !pready && !dec[2]) |=> pslverr && prdata == 32'h0000_0000)
        else $error("Unmapped access not refused");
    a_ur_exclusive: assert property (@(posedge clk) disable iff (rst)
        !(in_fwd.valid && in_ur.valid))
        else $error("Request both passed on and refused");
    a_atom_sticky: assert property (@(posedge clk) disable iff (rst)
        atom_err |=> sts_ff[`CCM_STS_ATOM_BIT])
        else $error("Blocked atomic not recorded");
    a_sts_set_wins: assert property (@(posedge clk) disable iff (rst)
        (wr_commit && dec == 3'h6 && in_ur.valid) |=> sts_ff[`CCM_STS_UR_BIT])
        else $error("Status clear beat a new event");
    a_aux_low: assert property (@(posedge clk) disable iff (rst)
        !aux_power_enable_out)
        else $error("Unused mirror not low");
endmodule
`default_nettype wire

// *** dv/ccm_user_model.sv ***
// Model of the user application logic beside the config mirror block
`default_nettype none
module ccm_user_model #(
    parameter bit ROOT_PORT = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic mem_en,
    input wire logic req_en,
    input wire logic bus_master,
    input wire logic tmo_dis,
    input wire logic [3:0] tmo_range,
    input wire ccm_pkg::ccm_eg_pkt_t want,
    output ccm_pkg::ccm_eg_pkt_t eg_pkt,
    output logic withheld
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] tmo_ff;
    logic hold;

    ////////////////////////////////////////////////////////////////////////
    // Packet issue, withheld where user logic may not send
    assign hold = (ROOT_PORT && !mem_en)
        || (want.kind == ccm_pkg::CCM_PKT_ATOMIC && !(req_en && bus_master));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eg_pkt <= '0;
            withheld <= 1'b0;
        end else if (!want.valid) begin
            eg_pkt <= {1'b0, ~eg_pkt[7:0]};
            withheld <= 1'b0;
        end else begin
            eg_pkt <= {!hold, want[7:0]};
            withheld <= hold;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Completion timeout counter, range held as given
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tmo_ff <= '0;
        end else if (tmo_dis) begin
            tmo_ff <= '0;
        end else begin
            tmo_ff <= tmo_ff + {12'h000, tmo_range} + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// *** dv/ccm_top_tb.sv ***
// Self-checking bench of the config mirror block
`default_nettype none
module ccm_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, bm, withheld;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    ccm_pkg::ccm_in_req_t in_req, in_fwd, in_ur;
    ccm_pkg::ccm_eg_pkt_t want, eg_pkt;
    ccm_pkg::ccm_eg_out_t eg_out;
    logic mem_o, serr_o, ari_o, ablk_o, areq_o, tdis_o, idoc_o, idor_o, ltr_o, pfx_o, aux_o;
    logic [3:0] trng_o;
    int n_mismatch, num_checks, cyc;
    logic err;

    ccm_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .in_req(in_req), .in_fwd(in_fwd), .in_ur(in_ur), .eg_pkt(eg_pkt), .eg_out(eg_out),
        .memory_space_enable_out(mem_o), .system_error_enable_out(serr_o),
        .alt_routing_forward_enable_out(ari_o), .atomic_egress_block_out(ablk_o),
        .atomic_requester_enable_out(areq_o), .completion_timeout_disable_out(tdis_o),
        .completion_timeout_range_out(trng_o), .id_order_completion_enable_out(idoc_o),
        .id_order_request_enable_out(idor_o), .latency_report_enable_out(ltr_o),
        .prefix_block_out(pfx_o), .aux_power_enable_out(aux_o));
    ccm_user_model partner (.clk(clk), .rst(rst), .mem_en(mem_o), .req_en(areq_o),
        .bus_master(bm), .tmo_dis(tdis_o), .tmo_range(trng_o), .want(want),
        .eg_pkt(eg_pkt), .withheld(withheld));

    ////////////////////////////////////////////////////////////////////////
    // Clock, reset, timeout
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch = n_mismatch + 1;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
    endtask
    task automatic in_send(input logic fwd, input logic ur);
        @(posedge clk);
        in_req <= '{1'b1, 1'b1, 1'b1, 8'h5a};
        @(posedge clk);
        in_req.valid <= 1'b0;
        @(posedge clk);
        chk(32'({in_fwd.valid, in_ur.valid}), 32'({fwd, ur}));
    endtask
    task automatic eg_send(input ccm_pkg::ccm_eg_pkt_t p, input ccm_pkg::ccm_eg_out_t e);
        @(posedge clk);
        want <= p;
        @(posedge clk);
        want.valid <= 1'b0;
        repeat (2) @(posedge clk);
        if (e.valid) chk(32'(eg_out), 32'(e));
        else chk(32'(eg_out.valid), 32'h0000_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        chk(32'({ari_o, ablk_o, areq_o, idoc_o, idor_o, pfx_o}), 32'h0000_0000);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 12'h00c, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
        $display("test reset done");
    endtask
    task automatic t_command();
        in_send(1'b0, 1'b1);
        apb(1'b1, 12'h000, 32'hffff_ffff);
        settle();
        chk(32'({mem_o, serr_o}), 32'h0000_0003);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(rd, 32'h0000_0102);
        in_send(1'b1, 1'b0);
        chk(32'(in_fwd.tag), 32'h0000_005a);
        $display("test command done");
    endtask
    task automatic t_devctl2();
        apb(1'b1, 12'h004, 32'h0000_ffff);
        settle();
        chk(32'({pfx_o, ltr_o, idoc_o, idor_o, ablk_o, areq_o, ari_o, tdis_o, trng_o, aux_o}),
            32'h0000_1ffe);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk(rd, 32'h0000_87ff);
        $display("test device control done");
    endtask
    task automatic t_egress();
        eg_send('{1'b1, ccm_pkg::CCM_PKT_PLAIN, 1'b1, 5'h03}, '0);
        eg_send('{1'b1, ccm_pkg::CCM_PKT_ATOMIC, 1'b0, 5'h03}, '0);
        eg_send('{1'b1, ccm_pkg::CCM_PKT_CFG_T1, 1'b0, 5'h13},
            '{1'b1, ccm_pkg::CCM_PKT_CFG_T1, 1'b0, 1'b1, 5'h13});
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(rd, 32'h0000_0007);
        apb(1'b1, 12'h008, 32'h0000_0007);
        apb(1'b1, 12'h004, 32'h0000_0000);
        settle();
        eg_send('{1'b1, ccm_pkg::CCM_PKT_CFG_T1, 1'b0, 5'h13},
            '{1'b1, ccm_pkg::CCM_PKT_CFG_T1, 1'b0, 1'b1, 5'h00});
        eg_send('{1'b1, ccm_pkg::CCM_PKT_PLAIN, 1'b1, 5'h03},
            '{1'b1, ccm_pkg::CCM_PKT_PLAIN, 1'b1, 1'b0, 5'h03});
        eg_send('{1'b1, ccm_pkg::CCM_PKT_ATOMIC, 1'b0, 5'h03}, '0);
        chk(32'(withheld), 32'h0000_0000);
        apb(1'b1, 12'h004, 32'h0000_0040);
        settle();
        eg_send('{1'b1, ccm_pkg::CCM_PKT_ATOMIC, 1'b0, 5'h03},
            '{1'b1, ccm_pkg::CCM_PKT_ATOMIC, 1'b0, 1'b0, 5'h03});
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("test egress done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence and verdict
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        in_req = '0;
        want = '0;
        bm = 1'b1;
        n_mismatch = 0;
        num_checks = 0;
        cyc = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_command();
        t_devctl2();
        t_egress();
        conclude();
    end
endmodule
`default_nettype wire
